// ==== verilog/ssfu_defines.vh ====
// Constants for the scan system flag unit: offsets, field positions, resets and timing
`ifndef SSFU_DEFINES_VH
`define SSFU_DEFINES_VH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SSFU_CLK_PERIOD_NS 10
`define SSFU_MS_NS 1000000
`define SSFU_MS_CYCLES (`SSFU_MS_NS / `SSFU_CLK_PERIOD_NS)

// Time-base periods in ms, as printed
`define SSFU_PER_20MS 20
`define SSFU_PER_100MS 100
`define SSFU_PER_200MS 200
`define SSFU_PER_1S 1000
`define SSFU_PER_2S 2000
`define SSFU_PER_10S 10000
`define SSFU_PER_20S 20000
`define SSFU_PER_60S 60000
`define SSFU_TB_COUNT 8

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SSFU_REG_SUMMARY 8'h00
`define SSFU_REG_FLAGS 8'h04
`define SSFU_REG_CONTROL 8'h08
`define SSFU_REG_WDLIMIT 8'h0C
`define SSFU_REG_DATE 8'h10
`define SSFU_REG_TOD 8'h14
`define SSFU_REG_WEEKDAY 8'h18
`define SSFU_REG_FAULTCNT 8'h1C
`define SSFU_REG_FAULTTAB 8'h20
`define SSFU_FAULT_DEPTH 8

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SSFU_CTL_INITDONE 0
`define SSFU_CTL_COLD 1
`define SSFU_CTL_CLRLATCH 2
`define SSFU_CTL_RESET 32'h0000_0002
`define SSFU_WDLIMIT_RESET 16'h00C8

// ----------------------------------------
// Fatal summary bit positions
// ----------------------------------------
`define SSFU_BIT_SLOTCFG 2
`define SSFU_BIT_IOFAIL 4
`define SSFU_BIT_SPFAIL 5
`define SSFU_BIT_EXTFAULT 6
`define SSFU_BIT_UNUSED 7
`define SSFU_BIT_OVERRUN 8
`define SSFU_BIT_BADINSTR 9
`define SSFU_BIT_STACK 10
`define SSFU_BIT_CORRUPT 11

// ----------------------------------------
// Calendar
// ----------------------------------------
// Weekday of the reference day, Monday counted as 0
`define SSFU_EPOCH_WDAY 17'h0_0006

`endif

// ==== verilog/ssfu_timebase.v ====
// Millisecond prescaler and half-period counters for the square-wave time bases
`include "ssfu_defines.vh"
`default_nettype none

module ssfu_timebase #(
  parameter MS_CYCLES = `SSFU_MS_CYCLES
) (
  input wire clk_sys,
  input wire rst_n,
  input wire restart,
  output wire msTick,
  output wire [7:0] halfDone
);

  // ----------------------------------------
  // Half periods in ms
  // ----------------------------------------
  function [15:0] ssfuHalfMs;
    input integer idx;
    integer per;
    begin
      case (idx)
        0: per = `SSFU_PER_20MS;
        1: per = `SSFU_PER_100MS;
        2: per = `SSFU_PER_200MS;
        3: per = `SSFU_PER_1S;
        4: per = `SSFU_PER_2S;
        5: per = `SSFU_PER_10S;
        6: per = `SSFU_PER_20S;
        default: per = `SSFU_PER_60S;
      endcase
      ssfuHalfMs = per[16:1];
    end
  endfunction

  localparam integer MS_LAST_I = MS_CYCLES - 1;
  localparam [16:0] MS_LAST = MS_LAST_I[16:0];

  reg [16:0] pre_q;
  reg msTick_q;
  reg [15:0] cnt_q [0:7];
  reg [7:0] halfDone_q;
  integer i;

  // ----------------------------------------
  // Prescaler and counters
  // ----------------------------------------
  // Counters restart with the program so every flag begins a fresh half period
  always @(posedge clk_sys) begin
    if (!rst_n || restart) begin
      pre_q <= 17'h0_0000;
      msTick_q <= 1'b0;
      halfDone_q <= 8'h00;
      for (i = 0; i < 8; i = i + 1) begin
        cnt_q[i] <= 16'h0000;
      end
    end else begin
      msTick_q <= (pre_q == MS_LAST);
      pre_q <= (pre_q == MS_LAST) ? 17'h0_0000 : pre_q + 17'h0_0001;
      for (i = 0; i < 8; i = i + 1) begin
        halfDone_q[i] <= 1'b0;
        if (msTick_q) begin
          if (cnt_q[i] == ssfuHalfMs(i) - 16'h0001) begin
            cnt_q[i] <= 16'h0000;
            halfDone_q[i] <= 1'b1; // [R03]
          end else begin
            cnt_q[i] <= cnt_q[i] + 16'h0001;
          end
        end
      end
    end
  end

  assign msTick = msTick_q;
  assign halfDone = halfDone_q;

endmodule
`default_nettype wire

// ==== verilog/ssfu_flag_unit.v ====
// Scan system flag unit: user flags, time bases, calendar view and fatal error summary
//
// Summary of operation
// R01: A block error sets a latch that holds until cleared or restart.
// R02: The operation error flag is rewritten after every executed operation.
// R03: Eight square-wave time bases, 20 ms to 60 s, invert each half period.
// R04: Pending time-base inversions are applied only at scan end.
// R05: All time bases go low when init or scan program begins.
// R06: One flag always reads high, another always reads low; the high flag resets low and rises on the first clock after reset.
// R07: First-scan-high flag is high only during the first scan.
// R08: First-scan-low flag is low only during the first scan.
// R09: Scan toggle inverts every scan while running, high in the first scan.
// R10: Setting init-complete ends the init program and starts the scan program.
// R11: Date counts days from 1 Jan 1984; time counts from midnight.
// R12: Weekday runs 0 for Monday up to 6 for Sunday.
// R13: Marked flags reinit at init start; afterwards follow restart mode.
// R14: Fatal errors gather into a 16-bit summary word, bit 7 unused.
// R15: Summary bit 2 sets on slot configuration change during operation.
// R16: Summary bit 4 sets on I/O module read or write failure.
// R17: Summary bit 5 sets on special or communications module failure.
// R18: Summary bit 6 sets on external fatal fault; code goes into table.
// R19: Summary bit 8 sets when a scan exceeds the watchdog limit.
// R20: Summary bit 9 sets on an undecodable instruction.
// R21: Summary bit 10 sets on stack overflow.
// R22: Summary bit 11 sets on corrupt memory or faulty program.
// R23: Fatal bits stay set until restart; scan-end strobe marks scan boundary.
`include "ssfu_defines.vh"
`default_nettype none

module ssfu_flag_unit #(
  parameter MS_CYCLES = `SSFU_MS_CYCLES
) (
  input wire clk_sys,
  input wire rst_n,
  input wire runStart,
  input wire runStop,
  input wire scanEnd,
  input wire opDone,
  input wire opErrIn,
  input wire blockErrEvt,
  input wire slotCfgEvt,
  input wire ioFailEvt,
  input wire spFailEvt,
  input wire extFaultEvt,
  input wire [15:0] extFaultCode,
  input wire badInstrEvt,
  input wire stackOvfEvt,
  input wire progCorruptEvt,
  input wire rtcValid,
  input wire [15:0] rtcDays,
  input wire [31:0] rtcTodMs,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output wire [31:0] rdata,
  output wire blockErrorLatch,
  output wire opError,
  output wire tick20ms,
  output wire tick100ms,
  output wire tick200ms,
  output wire tick1s,
  output wire tick2s,
  output wire tick10s,
  output wire tick20s,
  output wire tick60s,
  output wire alwaysHigh,
  output wire alwaysLow,
  output wire firstScanHigh,
  output wire firstScanLow,
  output wire scanAlternate,
  output wire initRunning,
  output wire scanRunning,
  output wire [15:0] calendarDate,
  output wire [31:0] timeOfDay,
  output wire [2:0] weekdayNumber,
  output wire [15:0] fatalErrorSummary
);

  // ----------------------------------------
  // States and helpers
  // ----------------------------------------
  localparam [1:0] ST_STOP = 2'h0;
  localparam [1:0] ST_INIT = 2'h1;
  localparam [1:0] ST_SCAN = 2'h2;

  function [2:0] ssfuWeekday;
    input [15:0] days;
    reg [16:0] s;
    reg [16:0] r;
    begin
      s = {1'b0, days} + `SSFU_EPOCH_WDAY;
      r = s % 17'h0_0007;
      ssfuWeekday = r[2:0];
    end
  endfunction

  function ssfuHit;
    input [7:0] a;
    input [7:0] off;
    begin
      ssfuHit = (a == off);
    end
  endfunction

  reg [1:0] state_q, state_d;
  reg [31:0] ctl_q;
  reg [15:0] wdLimit_q;
  reg [15:0] wdCnt_q;
  reg blockErr_q, opErr_q;
  reg [7:0] tb_q, tbPend_q;
  reg high_q, low_q;
  reg firstHigh_q, firstLow_q, alt_q;
  reg initRun_q, scanRun_q;
  reg [15:0] date_q;
  reg [31:0] tod_q;
  reg [2:0] wday_q;
  reg [15:0] sum_q, sum_d;
  reg [15:0] faultTab_q [0:7];
  reg [3:0] faultCnt_q;
  reg [31:0] rdata_q, rdata_d;
  integer i;

  wire msTick;
  wire [7:0] halfDone;
  wire ctlWr = wr && ssfuHit(addr, `SSFU_REG_CONTROL);
  wire initDoneWr = ctlWr && wdata[`SSFU_CTL_INITDONE] && (state_q == ST_INIT);
  wire scanBegin = initDoneWr; // [R10]
  wire progBegin = runStart || scanBegin;
  wire restartCold = runStart;
  wire operating = (state_q != ST_STOP);

  // ----------------------------------------
  // Time-base counters
  // ----------------------------------------
  ssfu_timebase #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timebase (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .restart(progBegin),
    .msTick(msTick),
    .halfDone(halfDone)
  );

  // ----------------------------------------
  // Run state
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_STOP: begin
        if (runStart) begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        if (runStop) begin
          state_d = ST_STOP;
        end else if (initDoneWr) begin
          state_d = ST_SCAN; // [R10]
        end
      end
      ST_SCAN: begin
        if (runStop) begin
          state_d = ST_STOP;
        end else if (runStart) begin
          state_d = ST_INIT;
        end
      end
      default: begin
        state_d = ST_STOP;
      end
    endcase
    if (state_q != ST_STOP && runStart && !runStop) begin
      state_d = ST_INIT;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= ST_STOP;
      initRun_q <= 1'b0;
      scanRun_q <= 1'b0;
    end else begin
      state_q <= state_d;
      initRun_q <= (state_d == ST_INIT);
      scanRun_q <= (state_d == ST_SCAN);
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  // The init-done bit is a command, so it is not kept in the stored control word
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ctl_q <= `SSFU_CTL_RESET;
      wdLimit_q <= `SSFU_WDLIMIT_RESET;
    end else begin
      if (ctlWr) begin
        ctl_q <= {29'h0000_0000, 1'b0, wdata[`SSFU_CTL_COLD], 1'b0};
      end
      if (wr && ssfuHit(addr, `SSFU_REG_WDLIMIT)) begin
        wdLimit_q <= wdata[15:0];
      end
    end
  end

  // ----------------------------------------
  // Operation error flags
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      blockErr_q <= 1'b0;
      opErr_q <= 1'b0;
    end else begin
      if (blockErrEvt) begin
        blockErr_q <= 1'b1; // [R01]
      end else if (runStart || (ctlWr && wdata[`SSFU_CTL_CLRLATCH])) begin
        blockErr_q <= 1'b0;
      end
      if (opDone) begin
        opErr_q <= opErrIn; // [R02]
      end
    end
  end

  // ----------------------------------------
  // Time bases and scan flags
  // ----------------------------------------
  // Edges wait for scan end, so a long scan stretches or skips half periods
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      tb_q <= 8'h00;
      tbPend_q <= 8'h00;
      high_q <= 1'b0;
      low_q <= 1'b0;
      firstHigh_q <= 1'b0;
      firstLow_q <= 1'b1;
      alt_q <= 1'b0;
    end else begin
      high_q <= 1'b1; // [R06]
      low_q <= 1'b0; // [R06]
      if (progBegin) begin
        tb_q <= 8'h00; // [R05] [R13]
        tbPend_q <= 8'h00;
      end else if (scanEnd && operating) begin
        tb_q <= tb_q ^ (tbPend_q ^ halfDone); // [R04]
        tbPend_q <= 8'h00;
      end else begin
        tbPend_q <= tbPend_q ^ halfDone; // [R03]
      end
      if (runStart || (scanBegin && ctl_q[`SSFU_CTL_COLD])) begin
        firstHigh_q <= 1'b1; // [R07] [R13]
        firstLow_q <= 1'b0; // [R08] [R13]
        alt_q <= 1'b1; // [R09] [R13]
      end else if (scanEnd && operating) begin
        firstHigh_q <= 1'b0; // [R07] [R23]
        firstLow_q <= 1'b1; // [R08]
        alt_q <= ~alt_q; // [R09]
      end
    end
  end

  // ----------------------------------------
  // Scan watchdog
  // ----------------------------------------
  // A limit of zero disables the check
  always @(posedge clk_sys) begin
    if (!rst_n || progBegin || scanEnd) begin
      wdCnt_q <= 16'h0000;
    end else if (operating && msTick && wdCnt_q != 16'hFFFF) begin
      wdCnt_q <= wdCnt_q + 16'h0001;
    end
  end

  wire overrun = operating && (wdLimit_q != 16'h0000) && (wdCnt_q >= wdLimit_q); // [R19]

  // ----------------------------------------
  // Fatal summary and external fault table
  // ----------------------------------------
  // Restart clears the word, but an event in the same cycle still lands
  always @* begin
    sum_d = restartCold ? 16'h0000 : sum_q; // [R23]
    if (slotCfgEvt && operating) begin
      sum_d[`SSFU_BIT_SLOTCFG] = 1'b1; // [R15]
    end
    if (ioFailEvt) begin
      sum_d[`SSFU_BIT_IOFAIL] = 1'b1; // [R16]
    end
    if (spFailEvt) begin
      sum_d[`SSFU_BIT_SPFAIL] = 1'b1; // [R17]
    end
    if (extFaultEvt && extFaultCode != 16'h0000) begin
      sum_d[`SSFU_BIT_EXTFAULT] = 1'b1; // [R18]
    end
    if (overrun) begin
      sum_d[`SSFU_BIT_OVERRUN] = 1'b1; // [R19]
    end
    if (badInstrEvt) begin
      sum_d[`SSFU_BIT_BADINSTR] = 1'b1; // [R20]
    end
    if (stackOvfEvt) begin
      sum_d[`SSFU_BIT_STACK] = 1'b1; // [R21]
    end
    if (progCorruptEvt) begin
      sum_d[`SSFU_BIT_CORRUPT] = 1'b1; // [R22]
    end
    sum_d[`SSFU_BIT_UNUSED] = 1'b0; // [R14]
    sum_d[1:0] = 2'h0;
    sum_d[3] = 1'b0;
    sum_d[15:12] = 4'h0;
  end

  // Codes beyond the table depth are dropped; code zero is not a fault
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sum_q <= 16'h0000;
      faultCnt_q <= 4'h0;
      for (i = 0; i < `SSFU_FAULT_DEPTH; i = i + 1) begin
        faultTab_q[i] <= 16'h0000;
      end
    end else begin
      sum_q <= sum_d; // [R14]
      if (extFaultEvt && extFaultCode != 16'h0000 && faultCnt_q < 4'h8) begin
        faultTab_q[faultCnt_q[2:0]] <= extFaultCode; // [R18]
        faultCnt_q <= faultCnt_q + 4'h1;
      end else if (restartCold) begin
        faultCnt_q <= 4'h0;
        for (i = 0; i < `SSFU_FAULT_DEPTH; i = i + 1) begin
          faultTab_q[i] <= 16'h0000;
        end
      end
    end
  end

  // ----------------------------------------
  // Calendar view
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      date_q <= 16'h0000;
      tod_q <= 32'h0000_0000;
      wday_q <= 3'h6;
    end else if (rtcValid) begin
      date_q <= rtcDays; // [R11]
      tod_q <= rtcTodMs; // [R11]
      wday_q <= ssfuWeekday(rtcDays); // [R12]
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Read data stand one cycle only; unmapped offsets read zero
  always @* begin
    rdata_d = 32'h0000_0000;
    if (rd) begin
      if (ssfuHit(addr, `SSFU_REG_SUMMARY)) begin
        rdata_d = {16'h0000, sum_q};
      end else if (ssfuHit(addr, `SSFU_REG_FLAGS)) begin
        rdata_d = {10'h000, scanRun_q, initRun_q, alt_q, firstLow_q, firstHigh_q,
                   low_q, high_q, opErr_q, blockErr_q, 1'b0, tb_q, 2'h0, state_q};
      end else if (ssfuHit(addr, `SSFU_REG_CONTROL)) begin
        rdata_d = ctl_q;
      end else if (ssfuHit(addr, `SSFU_REG_WDLIMIT)) begin
        rdata_d = {16'h0000, wdLimit_q};
      end else if (ssfuHit(addr, `SSFU_REG_DATE)) begin
        rdata_d = {16'h0000, date_q};
      end else if (ssfuHit(addr, `SSFU_REG_TOD)) begin
        rdata_d = tod_q;
      end else if (ssfuHit(addr, `SSFU_REG_WEEKDAY)) begin
        rdata_d = {29'h0000_0000, wday_q};
      end else if (ssfuHit(addr, `SSFU_REG_FAULTCNT)) begin
        rdata_d = {28'h000_0000, faultCnt_q};
      end else if (addr[7:5] == 3'h1 && addr[1:0] == 2'h0) begin
        rdata_d = {16'h0000, faultTab_q[addr[4:2]]};
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata = rdata_q;
  assign blockErrorLatch = blockErr_q;
  assign opError = opErr_q;
  assign tick20ms = tb_q[0];
  assign tick100ms = tb_q[1];
  assign tick200ms = tb_q[2];
  assign tick1s = tb_q[3];
  assign tick2s = tb_q[4];
  assign tick10s = tb_q[5];
  assign tick20s = tb_q[6];
  assign tick60s = tb_q[7];
  assign alwaysHigh = high_q;
  assign alwaysLow = low_q;
  assign firstScanHigh = firstHigh_q;
  assign firstScanLow = firstLow_q;
  assign scanAlternate = alt_q;
  assign initRunning = initRun_q;
  assign scanRunning = scanRun_q;
  assign calendarDate = date_q;
  assign timeOfDay = tod_q;
  assign weekdayNumber = wday_q;
  assign fatalErrorSummary = sum_q;

endmodule
`default_nettype wire

// ==== verif/ssfu_flag_unit_assertions.sv ====
// Port-level checks for the scan system flag unit
`include "ssfu_defines.vh"
`default_nettype none
module ssfu_flag_unit_assertions (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic runStart,
  input wire logic scanEnd,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] addr,
  input wire logic opDone,
  input wire logic opErrIn,
  input wire logic blockErrEvt,
  input wire logic ioFailEvt,
  input wire logic rtcValid,
  input wire logic [15:0] rtcDays,
  input wire logic [31:0] rdata,
  input wire logic blockErrorLatch,
  input wire logic opError,
  input wire logic tick20ms,
  input wire logic tick100ms,
  input wire logic tick60s,
  input wire logic alwaysHigh,
  input wire logic alwaysLow,
  input wire logic firstScanHigh,
  input wire logic firstScanLow,
  input wire logic scanAlternate,
  input wire logic initRunning,
  input wire logic scanRunning,
  input wire logic [2:0] weekdayNumber,
  input wire logic [15:0] fatalErrorSummary
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // Scan boundary steps
  // ----------------------------------------
  sequence s_fresh;
    firstScanHigh && !firstScanLow && scanAlternate && initRunning && !tick20ms && !tick100ms && !tick60s;
  endsequence
  sequence s_later;
    !firstScanHigh && firstScanLow && (scanAlternate == !$past(scanAlternate));
  endsequence

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // First edge out of reset still shows the reset value, hence the past term
  property p_const;
    $past(rst_n) |-> alwaysHigh && !alwaysLow;
  endproperty
  a_const: assert property (p_const) else $error("constant flags wrong");
  property p_op;
    opDone |=> opError == $past(opErrIn);
  endproperty
  a_op: assert property (p_op) else $error("operation error flag not rewritten");
  property p_latch;
    blockErrEvt || (blockErrorLatch && !runStart && !wr) |=> blockErrorLatch;
  endproperty
  a_latch: assert property (p_latch) else $error("block error latch lost");
  property p_io;
    ioFailEvt |=> fatalErrorSummary[`SSFU_BIT_IOFAIL];
  endproperty
  a_io: assert property (p_io) else $error("io failure bit not set");
  property p_sticky;
    !runStart |=> (fatalErrorSummary & $past(fatalErrorSummary)) == $past(fatalErrorSummary);
  endproperty
  a_sticky: assert property (p_sticky) else $error("fatal bit cleared without restart");
  property p_unused;
    (fatalErrorSummary & 16'hF08B) == 16'h0000;
  endproperty
  a_unused: assert property (p_unused) else $error("unused summary bit set");
  property p_start;
    runStart && !scanEnd |=> s_fresh;
  endproperty
  a_start: assert property (p_start) else $error("start flags wrong");
  property p_scan;
    scanEnd && (initRunning || scanRunning) && !runStart && !wr |=> s_later;
  endproperty
  a_scan: assert property (p_scan) else $error("scan end flags wrong");
  property p_tbhold;
    !scanEnd && !runStart && !wr |=> $stable({tick20ms, tick100ms, tick60s});
  endproperty
  a_tbhold: assert property (p_tbhold) else $error("time base moved off scan end");
  property p_rdsum;
    rd && addr == `SSFU_REG_SUMMARY |=> rdata == {16'h0000, $past(fatalErrorSummary)};
  endproperty
  a_rdsum: assert property (p_rdsum) else $error("summary read mismatch");
  property p_wday;
    rtcValid |=> weekdayNumber == 3'((({1'b0, $past(rtcDays)} + `SSFU_EPOCH_WDAY) % 17'h0_0007));
  endproperty
  a_wday: assert property (p_wday) else $error("weekday mismatch");
endmodule

bind ssfu_flag_unit ssfu_flag_unit_assertions chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .runStart(runStart), .scanEnd(scanEnd), .wr(wr), .rd(rd), .addr(addr),
  .opDone(opDone), .opErrIn(opErrIn), .blockErrEvt(blockErrEvt), .ioFailEvt(ioFailEvt), .rtcValid(rtcValid),
  .rtcDays(rtcDays), .rdata(rdata), .blockErrorLatch(blockErrorLatch), .opError(opError), .tick20ms(tick20ms),
  .tick100ms(tick100ms), .tick60s(tick60s), .alwaysHigh(alwaysHigh), .alwaysLow(alwaysLow),
  .firstScanHigh(firstScanHigh), .firstScanLow(firstScanLow), .scanAlternate(scanAlternate),
  .initRunning(initRunning), .scanRunning(scanRunning), .weekdayNumber(weekdayNumber),
  .fatalErrorSummary(fatalErrorSummary)
);
`default_nettype wire

// ==== verif/ssfu_flag_unit_test.sv ====
// Self-checking bench for the scan system flag unit
`include "ssfu_defines.vh"
`default_nettype none
module ssfu_flag_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int START = 0;
  localparam int STOP = 1;
  localparam int SEND = 2;
  localparam int OPD = 3;
  localparam int BLK = 4;
  localparam int RTC = 12;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [12:0] ev = 13'h0000;
  logic opErrIn = 1'b0;
  logic [15:0] extFaultCode = 16'h0000;
  logic [15:0] rtcDays = 16'h0000;
  logic [31:0] rtcTodMs = 32'h0000_0000;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [31:0] timeOfDay;
  logic [15:0] calendarDate;
  logic [15:0] summary;
  wire [7:0] tick;
  wire [8:0] fl;
  logic [2:0] weekdayNumber;
  int failures = 0;
  int totalChecks = 0;

  // Flag bits: 0 latch, 1 op error, 2 high, 3 low, 4 first high, 5 first low, 6 toggle, 7 init, 8 scan
  ssfu_flag_unit #(.MS_CYCLES(10)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .runStart(ev[0]), .runStop(ev[1]), .scanEnd(ev[2]), .opDone(ev[3]),
    .opErrIn(opErrIn), .blockErrEvt(ev[4]), .slotCfgEvt(ev[5]), .ioFailEvt(ev[6]), .spFailEvt(ev[7]),
    .extFaultEvt(ev[8]), .extFaultCode(extFaultCode), .badInstrEvt(ev[9]), .stackOvfEvt(ev[10]),
    .progCorruptEvt(ev[11]), .rtcValid(ev[12]), .rtcDays(rtcDays), .rtcTodMs(rtcTodMs), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .blockErrorLatch(fl[0]), .opError(fl[1]),
    .tick20ms(tick[0]), .tick100ms(tick[1]), .tick200ms(tick[2]), .tick1s(tick[3]), .tick2s(tick[4]),
    .tick10s(tick[5]), .tick20s(tick[6]), .tick60s(tick[7]), .alwaysHigh(fl[2]), .alwaysLow(fl[3]),
    .firstScanHigh(fl[4]), .firstScanLow(fl[5]), .scanAlternate(fl[6]), .initRunning(fl[7]),
    .scanRunning(fl[8]), .calendarDate(calendarDate), .timeOfDay(timeOfDay), .weekdayNumber(weekdayNumber),
    .fatalErrorSummary(summary)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // Ends one step past the edge that took the pulse, so outputs have settled
  task automatic pulse(input int i);
    @(posedge clk_sys) ev[i] <= 1'b1;
    @(posedge clk_sys) ev[i] <= 1'b0;
    #1;
  endtask
  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
    end
    @(posedge clk_sys) wr <= 1'b0;
    #1;
  endtask
  task automatic rdReg(input string nm, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys) begin
      addr <= a;
      rd <= 1'b1;
    end
    @(posedge clk_sys) rd <= 1'b0;
    #1 check(nm, exp, rdata);
  endtask
  task automatic wrap_up;
    $display("checks %0d, failures %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic tPowerUp;
    @(posedge clk_sys);
    #1 check("idle flags", 32'h0000_0009, 32'(fl[5:2]));
    check("weekday", 32'h0000_0006, 32'(weekdayNumber));
    rdReg("summary", `SSFU_REG_SUMMARY, 32'h0000_0000);
    rdReg("flags", `SSFU_REG_FLAGS, 32'h0004_8000);
    rdReg("control", `SSFU_REG_CONTROL, 32'h0000_0002);
    rdReg("unmapped", 8'h40, 32'h0000_0000);
  endtask
  task automatic tScanFlags;
    pulse(START);
    check("start flags", 32'h0000_000D, 32'(fl[8:4]));
    wrReg(`SSFU_REG_CONTROL, 32'h0000_0003);
    check("run state", 32'h0000_0002, 32'(fl[8:7]));
    for (int k = 0; k < 3; k++) begin
      pulse(SEND);
      check("scan end flags", 32'({k[0], 2'b10}), 32'(fl[6:4]));
    end
    // Warm begin keeps the scan flags; the stored mode bit counts, so it is set first
    wrReg(`SSFU_REG_CONTROL, 32'h0000_0000);
    pulse(START);
    pulse(SEND);
    wrReg(`SSFU_REG_CONTROL, 32'h0000_0001);
    check("warm first high", 32'h0000_0000, 32'(fl[4]));
    rdReg("control warm", `SSFU_REG_CONTROL, 32'h0000_0000);
    wrReg(`SSFU_REG_CONTROL, 32'h0000_0002);
    pulse(START);
    pulse(SEND);
    wrReg(`SSFU_REG_CONTROL, 32'h0000_0003);
    check("cold first high", 32'h0000_0001, 32'(fl[4]));
  endtask
  task automatic tTimeBase;
    pulse(START);
    wrReg(`SSFU_REG_CONTROL, 32'h0000_0003);
    repeat (150) @(posedge clk_sys);
    #1 check("ticks pending", 32'h0000_0000, 32'(tick));
    pulse(SEND);
    check("ticks 15ms", 32'h0000_0001, 32'(tick));
    repeat (400) @(posedge clk_sys);
    pulse(SEND);
    check("ticks 55ms", 32'h0000_0003, 32'(tick));
    pulse(START);
    check("ticks restart", 32'h0000_0000, 32'(tick));
  endtask
  task automatic tOpError;
    @(posedge clk_sys) opErrIn <= 1'b1;
    pulse(OPD);
    check("op error", 32'h0000_0001, 32'(fl[1]));
    @(posedge clk_sys) opErrIn <= 1'b0;
    pulse(OPD);
    check("op error", 32'h0000_0000, 32'(fl[1]));
    pulse(BLK);
    pulse(OPD);
    check("block latch held", 32'h0000_0001, 32'(fl[0]));
    wrReg(`SSFU_REG_CONTROL, 32'h0000_0006);
    check("block latch cleared", 32'h0000_0000, 32'(fl[0]));
  endtask
  task automatic tFatal;
    int pos[7] = '{2, 4, 5, 6, 9, 10, 11};
    logic [15:0] m = 16'h0000;
    pulse(START);
    wrReg(`SSFU_REG_CONTROL, 32'h0000_0003);
    @(posedge clk_sys) extFaultCode <= 16'h00A5;
    for (int i = 5; i < 12; i++) begin
      pulse(i);
      m = m | (16'h0001 << pos[i - 5]);
      rdReg("summary", `SSFU_REG_SUMMARY, {16'h0000, m});
    end
    rdReg("fault count", `SSFU_REG_FAULTCNT, 32'h0000_0001);
    rdReg("fault code", `SSFU_REG_FAULTTAB, 32'h0000_00A5);
    pulse(START);
    check("summary restart", 32'h0000_0000, 32'(summary));
    wrReg(`SSFU_REG_CONTROL, 32'h0000_0003);
    wrReg(`SSFU_REG_WDLIMIT, 32'h0000_0003);
    repeat (60) @(posedge clk_sys);
    rdReg("overrun", `SSFU_REG_SUMMARY, 32'h0000_0100);
    pulse(STOP);
    pulse(5);
    check("slot while stopped", 32'h0000_0100, 32'(summary));
  endtask
  task automatic tCalendar;
    logic [15:0] days[3] = '{16'h0000, 16'h0001, 16'h1234};
    logic [2:0] wd[3] = '{3'h6, 3'h0, 3'h4};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys) begin
        rtcDays <= days[i];
        rtcTodMs <= 32'h0526_5BFF;
      end
      pulse(RTC);
      check("weekday", 32'(wd[i]), 32'(weekdayNumber));
      check("date", 32'(days[i]), 32'(calendarDate));
      check("time of day", 32'h0526_5BFF, timeOfDay);
    end
  endtask

  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    tPowerUp();
    tScanFlags();
    tTimeBase();
    tOpError();
    tFatal();
    tCalendar();
    wrap_up();
  end
  // About 730 cycles are needed; the limit leaves wide margin
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
